// File: src/eac_pkg.sv
// Constants shared by the byte-wide nonvolatile data store access controller.
package eac_pkg;
  localparam logic [5:0]  OFS_CONTROL   = 6'h1f;
  localparam logic [5:0]  OFS_DATA      = 6'h20;
  localparam logic [5:0]  OFS_ADDR_LOW  = 6'h21;
  localparam logic [5:0]  OFS_ADDR_HIGH = 6'h22;

  localparam int          ADDR_W        = 12;
  localparam int          DEPTH         = 4096;

  localparam int          BIT_READ      = 0;
  localparam int          BIT_PROG      = 1;
  localparam int          BIT_MASTER    = 2;
  localparam int          BIT_RDY_IE    = 3;
  localparam int          MODE_LO       = 4;
  localparam int          MODE_HI       = 5;

  localparam logic [1:0]  MODE_ATOMIC   = 2'h0;
  localparam logic [1:0]  MODE_ERASE    = 2'h1;
  localparam logic [1:0]  MODE_WRITE    = 2'h2;
  localparam logic [1:0]  MODE_RESERVED = 2'h3;

  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [3:0]  RESERVED_HIGH = 4'h0;
  localparam logic [1:0]  RESERVED_CTRL = 2'h0;

  localparam logic [2:0]  MASTER_WINDOW = 3'h4;
  localparam logic [2:0]  STALL_PROG    = 3'h2;
  localparam logic [2:0]  STALL_READ    = 3'h4;

  localparam int          ATOMIC_OSC    = 26368;
  localparam int          SPLIT_OSC     = 13184;
  localparam int          OSC_CNT_W     = 15;

  typedef enum logic {
    EAC_IDLE = 1'b0,
    EAC_BUSY = 1'b1
  } eac_state_t;
endpackage

// File: src/eac_top.sv
// Access controller for an on-chip byte-wide data store behind core I/O registers.
//
// What this block does
// - Address bits 15:12 and control bits 7:6 always read back as zero.
// - A 12-bit address over low and high registers selects one of 4K bytes.
// - Address has no defined reset meaning; software loads it before access.
// - Data register gives the byte to program and receives the byte read.
// - Mode 00 erase plus write, 01 erase, 10 write, 11 reserved.
// - Mode field writes are ignored while the programming strobe is set.
// - System reset clears the mode field to 00 unless programming is running.
// - Ready interrupt is a level while enable, global enable and idle hold.
// - Master enable clears itself four clock cycles after software sets it.
// - Programming strobe starts a write only while master enable is set.
// - No programming starts while the core is programming its flash.
// - Hardware clears the programming strobe when the write time has elapsed.
// - Setting the programming strobe stalls the core for two cycles.
// - Read strobe fetches the byte at once and stalls the core four cycles.
// - While programming, reads are refused and the address cannot change.
// - Write duration counts 26,368 oscillator cycles for a full write.
// - Control bits: read strobe 0, program 1, master enable 2, ready enable 3.
// - A system reset during programming lets the running operation finish.
`timescale 1ns/1ps

module eac_top #(
  parameter int ATOMIC_OSC_CYCLES = eac_pkg::ATOMIC_OSC,  // Erase plus write length.
  parameter int SPLIT_OSC_CYCLES  = eac_pkg::SPLIT_OSC    // Erase or write length.
) (
  input  wire logic       ref_clk,              // CPU clock, 100 MHz.
  input  wire logic       rst,                  // System reset, async, high.
  input  wire logic       por,                  // Power-on reset, async, high.
  input  wire logic       clk_en,               // Freezes all state while low.
  input  wire logic [5:0] io_addr,              // I/O register offset.
  input  wire logic       io_wr,                // Write strobe, one cycle.
  input  wire logic       io_rd,                // Read strobe, one cycle.
  input  wire logic [7:0] io_wdata,             // Write data.
  output logic      [7:0] io_rdata,             // Read data, one cycle later.
  input  wire logic       global_irq_en,        // Core global interrupt enable.
  input  wire logic       flash_selfprog_busy,  // Core is programming flash.
  input  wire logic       rc_osc,               // Calibrated RC oscillator pin.
  output logic            cpu_stall,            // Holds the core while high.
  output logic            ready_irq             // Level ready interrupt.
);

  localparam logic [eac_pkg::OSC_CNT_W-1:0] ATOMIC_LOAD =
    eac_pkg::OSC_CNT_W'(ATOMIC_OSC_CYCLES);
  localparam logic [eac_pkg::OSC_CNT_W-1:0] SPLIT_LOAD =
    eac_pkg::OSC_CNT_W'(SPLIT_OSC_CYCLES);

  // Engine group, cleared at power-on; system reset clears only prog_mode, and only while idle, so it cannot cut a write short.
  eac_pkg::eac_state_t                 state;
  eac_pkg::eac_state_t                 next_state;
  logic [eac_pkg::ADDR_W-1:0]          byte_address_field;
  logic [eac_pkg::ADDR_W-1:0]          next_byte_address_field;
  logic [7:0]                          byte_data_register;
  logic [7:0]                          next_byte_data_register;
  logic [1:0]                          prog_mode;
  logic [1:0]                          next_prog_mode;
  logic [1:0]                          run_mode;
  logic [1:0]                          next_run_mode;
  logic [7:0]                          run_data;
  logic [7:0]                          next_run_data;
  logic [eac_pkg::OSC_CNT_W-1:0]       osc_cnt;
  logic [eac_pkg::OSC_CNT_W-1:0]       next_osc_cnt;

  // Software group, cleared by system reset.
  logic                                master_prog_enable;
  logic                                next_master_prog_enable;
  logic [2:0]                          master_cnt;
  logic [2:0]                          next_master_cnt;
  logic                                ready_irq_enable;
  logic                                next_ready_irq_enable;
  logic [2:0]                          stall_cnt;
  logic [2:0]                          next_stall_cnt;
  logic [7:0]                          rdata_q;
  logic [7:0]                          next_rdata_q;
  logic                                osc_meta;
  logic                                osc_sync;
  logic                                osc_prev;

  logic [7:0]                          mem [eac_pkg::DEPTH];
  logic                                mem_we;
  logic [7:0]                          mem_wdata;
  logic [7:0]                          mem_rbyte;
  logic                                prog_strobe;
  logic                                wr_en;
  logic                                ctrl_wr;
  logic                                start_prog;
  logic                                start_read;
  logic                                osc_edge;
  logic [7:0]                          ctrl_view;

  assign prog_strobe = (state == eac_pkg::EAC_BUSY);
  assign wr_en       = io_wr && !rst;
  assign ctrl_wr     = wr_en && (io_addr == eac_pkg::OFS_CONTROL);
  assign osc_edge    = osc_sync && !osc_prev;
  assign mem_rbyte   = mem[byte_address_field];

  // Reserved mode is refused here so the array is never touched by it.
  assign start_prog = ctrl_wr && io_wdata[eac_pkg::BIT_PROG] && master_prog_enable
                      && !prog_strobe
                      && !flash_selfprog_busy
                      && (io_wdata[eac_pkg::MODE_HI:eac_pkg::MODE_LO]
                          != eac_pkg::MODE_RESERVED);
  assign start_read = ctrl_wr && io_wdata[eac_pkg::BIT_READ] && !prog_strobe
                      && !start_prog;

  assign ctrl_view = {eac_pkg::RESERVED_CTRL, prog_mode, ready_irq_enable,
                      master_prog_enable, prog_strobe, 1'b0};

  always_comb begin
    next_state              = state;
    next_byte_address_field = byte_address_field;
    next_byte_data_register = byte_data_register;
    next_prog_mode          = prog_mode;
    next_run_mode           = run_mode;
    next_run_data           = run_data;
    next_osc_cnt            = osc_cnt;
    mem_we                  = 1'b0;
    mem_wdata               = run_data;
    if (wr_en && !prog_strobe && (io_addr == eac_pkg::OFS_ADDR_LOW)) begin
      next_byte_address_field[7:0] = io_wdata;
    end
    if (wr_en && !prog_strobe && (io_addr == eac_pkg::OFS_ADDR_HIGH)) begin
      next_byte_address_field[eac_pkg::ADDR_W-1:8] = io_wdata[eac_pkg::ADDR_W-9:0];
    end
    if (wr_en && (io_addr == eac_pkg::OFS_DATA)) begin
      next_byte_data_register = io_wdata;
    end
    if (ctrl_wr && !prog_strobe) begin
      next_prog_mode = io_wdata[eac_pkg::MODE_HI:eac_pkg::MODE_LO];
    end
    if (rst && !prog_strobe) begin
      next_prog_mode = eac_pkg::MODE_ATOMIC;
    end
    if (start_read) begin
      next_byte_data_register = mem_rbyte;
    end
    unique case (state)
      eac_pkg::EAC_IDLE: begin
        if (start_prog) begin
          next_state    = eac_pkg::EAC_BUSY;
          next_run_mode = io_wdata[eac_pkg::MODE_HI:eac_pkg::MODE_LO];
          // Data is latched at the strobe so a later data write cannot corrupt the byte.
          next_run_data = byte_data_register;
          next_osc_cnt  = (next_run_mode == eac_pkg::MODE_ATOMIC) ?
                          ATOMIC_LOAD : SPLIT_LOAD;
        end
      end
      eac_pkg::EAC_BUSY: begin
        if (osc_edge) begin
          next_osc_cnt = osc_cnt - 1'b1;
          if (osc_cnt == 1'b1) begin
            next_state = eac_pkg::EAC_IDLE;
            mem_we     = 1'b1;
            unique case (run_mode)
              eac_pkg::MODE_ERASE: mem_wdata = eac_pkg::ERASED_BYTE;
              eac_pkg::MODE_WRITE: mem_wdata = mem_rbyte & run_data;
              default:             mem_wdata = run_data;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge por) begin
    if (por) begin
      state              <= eac_pkg::EAC_IDLE;
      byte_address_field <= '0;
      byte_data_register <= '0;
      prog_mode          <= eac_pkg::MODE_ATOMIC;
      run_mode           <= eac_pkg::MODE_ATOMIC;
      run_data           <= '0;
      osc_cnt            <= '0;
    end else if (clk_en) begin
      state              <= next_state;
      byte_address_field <= next_byte_address_field;
      byte_data_register <= next_byte_data_register;
      prog_mode          <= next_prog_mode;
      run_mode           <= next_run_mode;
      run_data           <= next_run_data;
      osc_cnt            <= next_osc_cnt;
    end
  end

  // The array holds no reset; its contents are the stored data.
  always_ff @(posedge ref_clk) begin
    if (clk_en && mem_we) begin
      mem[byte_address_field] <= mem_wdata;
    end
  end

  always_comb begin
    next_master_prog_enable = master_prog_enable;
    next_master_cnt         = master_cnt;
    next_ready_irq_enable   = ready_irq_enable;
    next_stall_cnt          = (stall_cnt != 3'h0) ? stall_cnt - 3'h1 : stall_cnt;
    next_rdata_q            = rdata_q;
    if (master_prog_enable) begin
      next_master_cnt = master_cnt - 3'h1;
      if (master_cnt == 3'h1) begin
        next_master_prog_enable = 1'b0;
      end
    end
    if (ctrl_wr) begin
      next_ready_irq_enable = io_wdata[eac_pkg::BIT_RDY_IE];
      if (io_wdata[eac_pkg::BIT_MASTER]) begin
        next_master_prog_enable = 1'b1;
        next_master_cnt         = eac_pkg::MASTER_WINDOW;
      end
    end
    if (start_prog) begin
      next_master_prog_enable = 1'b0;
      next_stall_cnt          = eac_pkg::STALL_PROG;
    end
    if (start_read) begin
      next_stall_cnt = eac_pkg::STALL_READ;
    end
    if (io_rd) begin
      unique case (io_addr)
        eac_pkg::OFS_ADDR_LOW:  next_rdata_q = byte_address_field[7:0];
        eac_pkg::OFS_ADDR_HIGH: next_rdata_q = {eac_pkg::RESERVED_HIGH,
                                                byte_address_field[eac_pkg::ADDR_W-1:8]};
        eac_pkg::OFS_DATA:      next_rdata_q = byte_data_register;
        eac_pkg::OFS_CONTROL:   next_rdata_q = ctrl_view;
        default:                next_rdata_q = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      master_prog_enable <= 1'b0;
      master_cnt         <= 3'h0;
      ready_irq_enable   <= 1'b0;
      stall_cnt          <= 3'h0;
      rdata_q            <= 8'h00;
      osc_meta           <= 1'b0;
      osc_sync           <= 1'b0;
      osc_prev           <= 1'b0;
    end else if (clk_en) begin
      master_prog_enable <= next_master_prog_enable;
      master_cnt         <= next_master_cnt;
      ready_irq_enable   <= next_ready_irq_enable;
      stall_cnt          <= next_stall_cnt;
      rdata_q            <= next_rdata_q;
      osc_meta           <= rc_osc;
      osc_sync           <= osc_meta;
      osc_prev           <= osc_sync;
    end
  end

  assign io_rdata  = rdata_q;
  assign cpu_stall = (stall_cnt != 3'h0);
  assign ready_irq = ready_irq_enable && global_irq_en && !prog_strobe;

endmodule

// File: test/eac_top_asserts.sv
// Port-level assertions for the byte store access controller.
`timescale 1ns/1ps

module eac_top_asserts #(
  parameter int ATOMIC_OSC_CYCLES = 8,  // Erase plus write length.
  parameter int SPLIT_OSC_CYCLES  = 4   // Erase or write length.
) (
  input wire logic       ref_clk,              // Core clock.
  input wire logic       rst,                  // System reset.
  input wire logic       por,                  // Power-on reset.
  input wire logic       clk_en,               // Clock enable.
  input wire logic [5:0] io_addr,              // Register offset.
  input wire logic       io_wr,                // Write strobe.
  input wire logic       io_rd,                // Read strobe.
  input wire logic [7:0] io_wdata,             // Write data.
  input wire logic [7:0] io_rdata,             // Read data.
  input wire logic       global_irq_en,        // Global enable.
  input wire logic       flash_selfprog_busy,  // Flash busy.
  input wire logic       rc_osc,               // Oscillator.
  input wire logic       cpu_stall,            // Core hold.
  input wire logic       ready_irq             // Ready interrupt.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || por);

  wire logic rd_t  = io_rd && clk_en;
  wire logic ctl_w = io_wr && clk_en && (io_addr == eac_pkg::OFS_CONTROL);

  sequence read_hold;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence
  sequence prog_hold;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence

  chk_stall_cause: assert property ($rose(cpu_stall) |-> $past(ctl_w && io_wdata[1:0] != 2'h0))
    else $error("stall rose without a strobe write");
  chk_read_stall: assert property ($rose(cpu_stall) && $past(!io_wdata[1]) |-> read_hold)
    else $error("read stall length is wrong");
  chk_prog_stall: assert property ($rose(cpu_stall) && $past(io_wdata[1]) |-> prog_hold)
    else $error("program stall length is wrong");
  chk_irq_busy: assert property ($rose(cpu_stall) && $past(io_wdata[1]) |-> !ready_irq)
    else $error("ready interrupt high while programming");
  chk_irq_gate: assert property (ready_irq |-> global_irq_en)
    else $error("ready interrupt without global enable");
  chk_rdata_hold: assert property (!$past(rd_t) |-> $stable(io_rdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (rd_t && (io_addr < eac_pkg::OFS_CONTROL ||
    io_addr > eac_pkg::OFS_ADDR_HIGH) |=> io_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  chk_rsvd_high: assert property (rd_t && io_addr == eac_pkg::OFS_ADDR_HIGH |=> io_rdata[7:4] == 4'h0)
    else $error("address high reserved bits nonzero");
  chk_rsvd_ctrl: assert property (rd_t && io_addr == eac_pkg::OFS_CONTROL |=>
    io_rdata[7:6] == 2'h0 && !io_rdata[0])
    else $error("control reserved or read bit nonzero");
endmodule

bind eac_top eac_top_asserts #(.ATOMIC_OSC_CYCLES(ATOMIC_OSC_CYCLES),
  .SPLIT_OSC_CYCLES(SPLIT_OSC_CYCLES)) u_chk (.ref_clk(ref_clk), .rst(rst), .por(por),
  .clk_en(clk_en), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .global_irq_en(global_irq_en),
  .flash_selfprog_busy(flash_selfprog_busy), .rc_osc(rc_osc), .cpu_stall(cpu_stall),
  .ready_irq(ready_irq));

// File: test/eac_top_bench.sv
// Self-checking bench for the byte store access controller, with an array model.
`timescale 1ns/1ps

module eac_top_bench;
  localparam logic [5:0] CTL = eac_pkg::OFS_CONTROL;
  localparam logic [5:0] ALO = eac_pkg::OFS_ADDR_LOW;
  localparam logic [5:0] AHI = eac_pkg::OFS_ADDR_HIGH;
  logic        ref_clk, rst, por, clk_en, io_wr, io_rd, global_irq_en;
  logic        flash_selfprog_busy, rc_osc, cpu_stall, ready_irq, rie;
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, got, d;
  logic [11:0] a;
  logic [1:0]  ml [3];
  logic [7:0]  mem [bit [11:0]];
  int          err_count, n_checks;

  eac_top #(.ATOMIC_OSC_CYCLES(8), .SPLIT_OSC_CYCLES(4)) i_dut (.ref_clk(ref_clk),
    .rst(rst), .por(por), .clk_en(clk_en), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_en(global_irq_en),
    .flash_selfprog_busy(flash_selfprog_busy), .rc_osc(rc_osc), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // The oscillator runs free at a 34 ns period, so its edges line up with a core clock edge only every 170 ns.
  initial begin
    rc_osc = 1'b0;
    forever #17 rc_osc = ~rc_osc;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    report_and_stop;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // A halted core issues nothing, so every access waits out the stall first.
  task automatic acc(input logic [5:0] ad, input logic [7:0] wd, input logic w);
    do @(posedge ref_clk); while (cpu_stall === 1'b1);
    io_addr <= ad;
    io_wdata <= wd;
    io_wr <= w;
    io_rd <= !w;
    @(posedge ref_clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1 got = io_rdata;
  endtask

  task automatic rdc(input logic [5:0] ad, input logic [7:0] mask, input logic [7:0] exp);
    acc(ad, 8'h00, 1'b0);
    check(got & mask, exp);
  endtask

  task automatic start(input logic [11:0] ad, input logic [7:0] dv, input logic [1:0] m);
    acc(ALO, ad[7:0], 1'b1);
    acc(AHI, {4'h0, ad[11:8]}, 1'b1);
    acc(eac_pkg::OFS_DATA, dv, 1'b1);
    acc(CTL, {2'h0, m, rie, 3'h4}, 1'b1);
    acc(CTL, {2'h0, m, rie, 3'h2}, 1'b1);
  endtask

  task automatic readback(input logic [11:0] ad);
    acc(ALO, ad[7:0], 1'b1);
    acc(AHI, {4'h0, ad[11:8]}, 1'b1);
    acc(CTL, {4'h0, rie, 3'h1}, 1'b1);
    acc(eac_pkg::OFS_DATA, 8'h00, 1'b0);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      acc(CTL, 8'h00, 1'b0);
      n++;
    end while (got[1] !== 1'b0 && n < 300);
    // A write that never finishes would hang the run, so it ends the run here.
    if (n >= 300) begin
      err_count++;
      report_and_stop;
    end
  endtask

  function automatic logic [7:0] model(input logic [7:0] old, input logic [7:0] dv,
                                       input logic [1:0] m);
    case (m)
      2'h0: return dv;
      2'h1: return 8'hff;
      2'h2: return old & dv;
      default: return old;
    endcase
  endfunction

  initial begin
    {rst, por, clk_en} = 3'h7;
    {io_wr, io_rd, global_irq_en, flash_selfprog_busy, rie} = 5'h0;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    err_count = 0;
    n_checks = 0;
    ml = '{2'h2, 2'h1, 2'h3};
    void'($urandom(32'h97aa));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    rdc(CTL, 8'hff, 8'h00);
    acc(AHI, 8'hff, 1'b1);
    rdc(AHI, 8'hff, 8'h0f);
    rdc(6'h3f, 8'hff, 8'h00);
    acc(CTL, 8'h04, 1'b1);
    rdc(CTL, 8'hff, 8'h04);
    @(posedge ref_clk);
    rdc(CTL, 8'hff, 8'h00);
    acc(CTL, 8'h02, 1'b1);
    rdc(CTL, 8'hff, 8'h00);
    $display("test reset_and_master done");
    for (int i = 0; i < 6; i++) begin
      a = 12'($urandom);
      d = 8'($urandom);
      rie = i[0];
      // Nothing in the bench can interrupt a write sequence, even with the enable high.
      global_irq_en <= (i < 4);
      start(a, d, 2'h0);
      check({7'h0, ready_irq}, 8'h00);
      mem[a] = d;
      wait_idle;
      check({7'h0, ready_irq}, {7'h0, rie & global_irq_en});
      foreach (ml[k]) begin
        d = 8'($urandom);
        start(a, d, ml[k]);
        rdc(CTL, 8'hfb, {2'h0, ml[k], rie, 1'b0, ml[k] != 2'h3, 1'b0});
        mem[a] = model(mem[a], d, ml[k]);
        wait_idle;
        readback(a);
        check(got, mem[a]);
      end
    end
    $display("test modes done");
    start(a, 8'h5a, 2'h0);
    acc(ALO, ~a[7:0], 1'b1);
    acc(CTL, {2'h0, 2'h3, rie, 3'h1}, 1'b1);
    rdc(CTL, 8'hfb, {3'h0, 1'b0, rie, 3'h2});
    mem[a] = 8'h5a;
    wait_idle;
    rdc(ALO, 8'hff, a[7:0]);
    readback(a);
    check(got, mem[a]);
    flash_selfprog_busy <= 1'b1;
    start(a, 8'h00, 2'h0);
    rdc(CTL, 8'h02, 8'h00);
    flash_selfprog_busy <= 1'b0;
    $display("test refusals done");
    start(a, 8'h0f, 2'h2);
    mem[a] = mem[a] & 8'h0f;
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rie = 1'b0;
    rdc(CTL, 8'hfb, 8'h22);
    wait_idle;
    readback(a);
    check(got, mem[a]);
    acc(CTL, 8'h10, 1'b1);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rdc(CTL, 8'hff, 8'h00);
    clk_en <= 1'b0;
    acc(ALO, ~a[7:0], 1'b1);
    clk_en <= 1'b1;
    rdc(ALO, 8'hff, a[7:0]);
    $display("test reset_during_write done");
    report_and_stop;
  end
endmodule
